// File: include/split_defs.svh
`ifndef SPLIT_DEFS_SVH
`define SPLIT_DEFS_SVH

// Token field widths and data byte width
`define DEV_ADDR_W      7
`define ENDPT_W         4
`define BYTE_W          8

// Buffer table defaults
`define NUM_BUFS_DEF    2
`define BUF_BYTES_DEF   64
`define SCAN_IDX_INIT   0

// Wait for the next packet of a start-split
`define CLK_PERIOD_NS   4
`define PKT_WAIT_NS     1000
`define PKT_WAIT_CYC    ((`PKT_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: include/split_pkg.sv
package split_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_TOKEN  = 4'h2,
    ST_DATA   = 4'h4,
    ST_ANSWER = 4'h8
  } hs_state_type;

  typedef enum logic [2:0] {
    BUF_OLD     = 3'h1,
    BUF_PENDING = 3'h2,
    BUF_READY   = 3'h4
  } buf_state_type;

  typedef enum logic [2:0] {
    HIT_FRESH  = 3'h1,
    HIT_REPEAT = 3'h2,
    HIT_FULL   = 3'h4
  } hit_type;

  typedef enum logic [2:0] {
    TOK_OUT   = 3'h1,
    TOK_IN    = 3'h2,
    TOK_SETUP = 3'h4
  } tok_type;

  typedef enum logic [1:0] {
    HS_ACK = 2'h1,
    HS_NAK = 2'h2
  } handshake_type;

  typedef enum logic [2:0] {
    CS_NYET   = 3'h1,
    CS_RESULT = 3'h2,
    CS_STALL  = 3'h4
  } cs_answer_type;

  typedef enum logic [3:0] {
    FS_ACK   = 4'h1,
    FS_NAK   = 4'h2,
    FS_STALL = 4'h4,
    FS_DATA  = 4'h8
  } fs_result_type;

endpackage

// File: include/buf_mem_if.sv
`timescale 1ns/100ps
interface buf_mem_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic          wa_en;
  logic [AW-1:0] wa_addr;
  logic [DW-1:0] wa_data;
  logic          wb_en;
  logic [AW-1:0] wb_addr;
  logic [DW-1:0] wb_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctrl (output wa_en, wa_addr, wa_data, wb_en, wb_addr, wb_data, rd_en, rd_addr,
                input  rd_data);
  modport mem  (input  wa_en, wa_addr, wa_data, wb_en, wb_addr, wb_data, rd_en, rd_addr,
                output rd_data);
endinterface

// File: core/split_payload_mem.sv
`timescale 1ns/100ps
module split_payload_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock
  input  wire logic clk_i,
  // Memory ports
  buf_mem_if.mem    mif
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_q;

  // Port a wins a same-address collision
  always_ff @(posedge clk_i) begin
    if (mif.wb_en) begin
      mem_q[mif.wb_addr] <= mif.wb_data;
    end
    if (mif.wa_en) begin
      mem_q[mif.wa_addr] <= mif.wa_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (mif.rd_en) begin
      rd_q <= mem_q[mif.rd_addr];
    end
  end

  assign mif.rd_data = rd_q;
endmodule

// File: core/split_bulk_start.sv
`timescale 1ns/100ps
`include "split_defs.svh"

// Summary of operation
// RL1: At least two bulk/control buffers, each one downstream transaction.
// RL2: Buffer holds start-split info and OUT data, then result and IN data.
// RL3: Any bulk/control start-split is accepted while a suitable buffer is free.
// RL4: Buffer whose results went back on a complete-split takes the next start-split.
// RL5: Only free space and host arrival order decide which start-split is accepted.
// RL6: Host tracks whether each scheduled transaction is plain or split.
// RL7: At most one buffered transaction and one result per endpoint.
// RL8: Match on address and endpoint; direction too for bulk, never for control.
// RL9: Lookup starts with no space and index zero, then scans all buffers.
// RL10: Match in pending or ready means repeat, otherwise fresh; first match ends scan.
// RL11: Non-matching old buffer is chosen as free, request counted fresh.
// RL12: Host sends start-split, OUT or SETUP token, then DATA0/DATA1.
// RL13: Missing token or data packet gets no handshake.
// RL14: Data packet with bad CRC gets no handshake.
// RL15: Host retries failing start-split until three errors, may interleave others.
// RL16: No buffer available answers NAK.
// RL17: Host keeps error tally on NAK and retries later.
// RL18: After NAK host may skip start-splits to this translator until a complete-split.
// RL19: Fresh start-split with free buffer is stored and answered ACK.
// RL20: After ACK host must do the complete-split before another start-split.
// RL21: Repeat start-split answers ACK and discards its payload.
// RL22: Host clears tally on success, not counting host-side delays.
// RL23: Host halts endpoint once tally reaches three.
// RL24: Pending buffer still waits for the downstream bus.
// RL25: Answered complete-split turns a ready buffer old.
module split_bulk_start
  import split_pkg::*;
#(
  parameter int NUM_BUFS  = `NUM_BUFS_DEF,
  parameter int BUF_BYTES = `BUF_BYTES_DEF,
  parameter int WAIT_CYC  = `PKT_WAIT_CYC,
  localparam int IW = (NUM_BUFS > 1) ? $clog2(NUM_BUFS) : 1,
  localparam int OW = $clog2(BUF_BYTES),
  localparam int LW = OW + 1
) (
  // Clock and reset
  input  wire logic                   REF_CLK_I,
  input  wire logic                   RST_I,
  // Start-split packets from the high-speed receiver
  input  wire logic                   SS_TOKEN_I,
  input  wire logic [`DEV_ADDR_W-1:0] SS_ADDR_I,
  input  wire logic [`ENDPT_W-1:0]    SS_EP_I,
  input  wire logic                   SS_CTRL_I,
  input  wire logic                   TOKEN_VALID_I,
  input  wire tok_type                TOKEN_KIND_I,
  input  wire logic                   DATA_BYTE_VALID_I,
  input  wire logic [`BYTE_W-1:0]     DATA_BYTE_I,
  input  wire logic                   DATA_END_I,
  input  wire logic                   DATA_CRC_OK_I,
  // Handshake to the high-speed transmitter
  output handshake_type               HS_HANDSHAKE_O,
  output logic                        HS_HANDSHAKE_VALID_O,
  // Downstream full-/low-speed handler
  output logic                        FS_REQ_VALID_O,
  output logic [IW-1:0]               FS_REQ_INDEX_O,
  output logic [`DEV_ADDR_W-1:0]      FS_REQ_ADDR_O,
  output logic [`ENDPT_W-1:0]         FS_REQ_EP_O,
  output tok_type                     FS_REQ_KIND_O,
  output logic [LW-1:0]               FS_REQ_LENGTH_O,
  input  wire logic                   FS_TAKE_I,
  input  wire logic                   FS_WR_VALID_I,
  input  wire logic [OW-1:0]          FS_WR_OFFSET_I,
  input  wire logic [`BYTE_W-1:0]     FS_WR_DATA_I,
  input  wire logic                   FS_DONE_I,
  input  wire fs_result_type          FS_RESULT_I,
  input  wire logic [LW-1:0]          FS_LENGTH_I,
  // Complete-split lookup and release
  input  wire logic                   CS_LOOKUP_I,
  input  wire logic [`DEV_ADDR_W-1:0] CS_ADDR_I,
  input  wire logic [`ENDPT_W-1:0]    CS_EP_I,
  input  wire logic                   CS_CTRL_I,
  input  wire logic                   CS_DIR_IN_I,
  output logic                        CS_ANSWER_VALID_O,
  output cs_answer_type               CS_ANSWER_O,
  output logic [IW-1:0]               CS_INDEX_O,
  output fs_result_type               CS_RESULT_O,
  output logic [LW-1:0]               CS_LENGTH_O,
  input  wire logic                   CS_DONE_I,
  input  wire logic [IW-1:0]          CS_DONE_INDEX_I,
  // Payload read port
  input  wire logic                   RD_EN_I,
  input  wire logic [IW-1:0]          RD_INDEX_I,
  input  wire logic [OW-1:0]          RD_OFFSET_I,
  output logic [`BYTE_W-1:0]          RD_DATA_O
);
  localparam int CW = $clog2(WAIT_CYC + 1);

  hs_state_type                 st_q;
  logic [`DEV_ADDR_W-1:0]       ss_addr_q;
  logic [`ENDPT_W-1:0]          ss_ep_q;
  logic                         ss_ctrl_q;
  tok_type                      tok_q;
  hit_type                      hit_q;
  logic [IW-1:0]                idx_q;
  logic [LW-1:0]                len_q;
  logic [CW-1:0]                wait_q;
  logic                         commit;
  logic                         timeout;
  hit_type                      scan_hit;
  logic [IW-1:0]                scan_idx;
  logic                         scan_found;
  logic                         cs_found;
  logic [IW-1:0]                cs_idx;
  logic                         pend_any;
  logic [IW-1:0]                pend_idx;
  logic                         fs_busy_q;
  logic [IW-1:0]                fs_idx_q;
  // RL1: buffer table sized by NUM_BUFS
  buf_state_type                ent_state_q [NUM_BUFS];
  logic [`DEV_ADDR_W-1:0]       ent_addr_q  [NUM_BUFS];
  logic [`ENDPT_W-1:0]          ent_ep_q    [NUM_BUFS];
  logic                         ent_ctrl_q  [NUM_BUFS];
  tok_type                      ent_tok_q   [NUM_BUFS];
  fs_result_type                ent_res_q   [NUM_BUFS];
  logic [LW-1:0]                ent_len_q   [NUM_BUFS];

  buf_mem_if #(.AW(IW + OW), .DW(`BYTE_W)) mif ();

  split_payload_mem #(
    .AW (IW + OW),
    .DW (`BYTE_W)
  ) u_mem (
    .clk_i (REF_CLK_I),
    .mif   (mif.mem)
  );

  // RL8: endpoint match, direction ignored for control
  function automatic logic ent_match(input int i, input logic [`DEV_ADDR_W-1:0] a,
                                     input logic [`ENDPT_W-1:0] e, input logic ctl,
                                     input logic dir_in);
    logic dir_ok;
    dir_ok = ((ent_tok_q[i] == TOK_IN) == dir_in) && !ctl;
    return (ent_ep_q[i] == e) && (ent_addr_q[i] == a) && (dir_ok || ctl);
  endfunction

  // RL3: every old buffer is a candidate
  // RL9: assume no space, index zero, scan all
  always_comb begin
    scan_hit   = HIT_FULL;
    scan_idx   = IW'(`SCAN_IDX_INIT);
    scan_found = 1'b0;
    for (int i = 0; i < NUM_BUFS; i++) begin
      if (!scan_found) begin
        if (ent_match(i, ss_addr_q, ss_ep_q, ss_ctrl_q, TOKEN_KIND_I == TOK_IN)) begin
          // RL10: pending or ready match is a retry
          if (ent_state_q[i] == BUF_READY || ent_state_q[i] == BUF_PENDING) begin
            scan_hit = HIT_REPEAT;
          end else begin
            scan_hit = HIT_FRESH;
          end
          scan_idx   = IW'(i);
          scan_found = 1'b1;
        // RL11: reuse an old buffer
        end else if (ent_state_q[i] == BUF_OLD) begin
          scan_hit = HIT_FRESH;
          scan_idx = IW'(i);
        end
      end
    end
  end

  assign timeout = (wait_q == CW'(WAIT_CYC - 1));
  // RL19: store a fresh start-split
  assign commit  = (st_q == ST_ANSWER) && (hit_q == HIT_FRESH);

  // RL12: start-split, token, then data
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      st_q      <= ST_IDLE;
      ss_addr_q <= '0;
      ss_ep_q   <= '0;
      ss_ctrl_q <= 1'b0;
      tok_q     <= TOK_OUT;
      hit_q     <= HIT_FULL;
      idx_q     <= '0;
      len_q     <= '0;
      wait_q    <= '0;
    end else if (SS_TOKEN_I) begin
      st_q      <= ST_TOKEN;
      ss_addr_q <= SS_ADDR_I;
      ss_ep_q   <= SS_EP_I;
      ss_ctrl_q <= SS_CTRL_I;
      len_q     <= '0;
      wait_q    <= '0;
    end else begin
      wait_q <= wait_q + CW'(1);
      unique case (st_q)
        ST_IDLE: begin
          wait_q <= '0;
        end
        ST_TOKEN: begin
          if (TOKEN_VALID_I) begin
            // RL5: decided by buffer state at arrival only
            tok_q  <= TOKEN_KIND_I;
            hit_q  <= scan_hit;
            idx_q  <= scan_idx;
            wait_q <= '0;
            st_q   <= (TOKEN_KIND_I == TOK_IN) ? ST_ANSWER : ST_DATA;
          // RL13: silent on missing token
          end else if (timeout) begin
            st_q <= ST_IDLE;
          end
        end
        ST_DATA: begin
          if (DATA_BYTE_VALID_I) begin
            wait_q <= '0;
            if (len_q < LW'(BUF_BYTES)) begin
              len_q <= len_q + LW'(1);
            end
          end
          if (DATA_END_I) begin
            // RL14: bad CRC gets no handshake
            st_q <= DATA_CRC_OK_I ? ST_ANSWER : ST_IDLE;
          // RL13: silent on missing data
          end else if (timeout && !DATA_BYTE_VALID_I) begin
            st_q <= ST_IDLE;
          end
        end
        ST_ANSWER: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // RL16: NAK when full, ACK otherwise
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      HS_HANDSHAKE_VALID_O <= 1'b0;
      HS_HANDSHAKE_O       <= HS_ACK;
    end else begin
      HS_HANDSHAKE_VALID_O <= (st_q == ST_ANSWER) && !SS_TOKEN_I;
      HS_HANDSHAKE_O       <= (hit_q == HIT_FULL) ? HS_NAK : HS_ACK;
    end
  end

  // RL21: payload written only for fresh start-splits
  assign mif.wa_en   = (st_q == ST_DATA) && DATA_BYTE_VALID_I && !SS_TOKEN_I &&
                       (hit_q == HIT_FRESH) && (len_q < LW'(BUF_BYTES));
  assign mif.wa_addr = {idx_q, len_q[OW-1:0]};
  assign mif.wa_data = DATA_BYTE_I;
  // RL2: IN payload from the downstream side
  assign mif.wb_en   = FS_WR_VALID_I && fs_busy_q;
  assign mif.wb_addr = {fs_idx_q, FS_WR_OFFSET_I};
  assign mif.wb_data = FS_WR_DATA_I;
  assign mif.rd_en   = RD_EN_I;
  assign mif.rd_addr = {RD_INDEX_I, RD_OFFSET_I};
  assign RD_DATA_O   = mif.rd_data;

  // RL7: one entry per endpoint kept by the lookup
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < NUM_BUFS; i++) begin
        ent_state_q[i] <= BUF_OLD;
        ent_addr_q[i]  <= '0;
        ent_ep_q[i]    <= '0;
        ent_ctrl_q[i]  <= 1'b0;
        ent_tok_q[i]   <= TOK_OUT;
        ent_res_q[i]   <= FS_ACK;
        ent_len_q[i]   <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_BUFS; i++) begin
        // RL2: record start-split information
        if (commit && !SS_TOKEN_I && idx_q == IW'(i)) begin
          ent_state_q[i] <= BUF_PENDING;
          ent_addr_q[i]  <= ss_addr_q;
          ent_ep_q[i]    <= ss_ep_q;
          ent_ctrl_q[i]  <= ss_ctrl_q;
          ent_tok_q[i]   <= tok_q;
          ent_len_q[i]   <= len_q;
        end
        // RL24: pending until downstream finishes
        if (FS_DONE_I && fs_busy_q && fs_idx_q == IW'(i) && ent_state_q[i] == BUF_PENDING) begin
          ent_state_q[i] <= BUF_READY;
          ent_res_q[i]   <= FS_RESULT_I;
          ent_len_q[i]   <= FS_LENGTH_I;
        end
        // RL25: ready becomes old
        // RL4: buffer free for next start-split
        if (CS_DONE_I && CS_DONE_INDEX_I == IW'(i) && ent_state_q[i] == BUF_READY) begin
          ent_state_q[i] <= BUF_OLD;
        end
      end
    end
  end

  always_comb begin
    pend_any = 1'b0;
    pend_idx = '0;
    cs_found = 1'b0;
    cs_idx   = '0;
    for (int i = NUM_BUFS - 1; i >= 0; i--) begin
      if (ent_state_q[i] == BUF_PENDING) begin
        pend_any = 1'b1;
        pend_idx = IW'(i);
      end
      if (ent_state_q[i] != BUF_OLD && ent_match(i, CS_ADDR_I, CS_EP_I, CS_CTRL_I, CS_DIR_IN_I)) begin
        cs_found = 1'b1;
        cs_idx   = IW'(i);
      end
    end
  end

  // Offer the lowest pending buffer downstream
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      fs_busy_q       <= 1'b0;
      fs_idx_q        <= '0;
      FS_REQ_VALID_O  <= 1'b0;
      FS_REQ_INDEX_O  <= '0;
      FS_REQ_ADDR_O   <= '0;
      FS_REQ_EP_O     <= '0;
      FS_REQ_KIND_O   <= TOK_OUT;
      FS_REQ_LENGTH_O <= '0;
    end else if (fs_busy_q) begin
      FS_REQ_VALID_O <= 1'b0;
      if (FS_DONE_I) begin
        fs_busy_q <= 1'b0;
      end
    end else if (FS_REQ_VALID_O) begin
      // Offer stands unchanged until taken
      if (FS_TAKE_I) begin
        fs_busy_q      <= 1'b1;
        fs_idx_q       <= FS_REQ_INDEX_O;
        FS_REQ_VALID_O <= 1'b0;
      end
    end else begin
      FS_REQ_VALID_O  <= pend_any;
      FS_REQ_INDEX_O  <= pend_idx;
      FS_REQ_ADDR_O   <= ent_addr_q[pend_idx];
      FS_REQ_EP_O     <= ent_ep_q[pend_idx];
      FS_REQ_KIND_O   <= ent_tok_q[pend_idx];
      FS_REQ_LENGTH_O <= ent_len_q[pend_idx];
    end
  end

  // Complete-split answer: result, not yet, or no entry
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      CS_ANSWER_VALID_O <= 1'b0;
      CS_ANSWER_O       <= CS_STALL;
      CS_INDEX_O        <= '0;
      CS_RESULT_O       <= FS_ACK;
      CS_LENGTH_O       <= '0;
    end else begin
      CS_ANSWER_VALID_O <= CS_LOOKUP_I;
      if (CS_LOOKUP_I) begin
        CS_INDEX_O  <= cs_idx;
        CS_RESULT_O <= ent_res_q[cs_idx];
        CS_LENGTH_O <= ent_len_q[cs_idx];
        if (!cs_found) begin
          CS_ANSWER_O <= CS_STALL;
        end else if (ent_state_q[cs_idx] == BUF_READY) begin
          CS_ANSWER_O <= CS_RESULT;
        end else begin
          CS_ANSWER_O <= CS_NYET;
        end
      end
    end
  end
endmodule

// File: sim/split_bulk_start_props.sv
`timescale 1ns/100ps
module split_bulk_start_props
  import split_pkg::*;
#(
  parameter int  NUM_BUFS = 2,
  parameter int  WAIT_CYC = 8,
  localparam int IW       = (NUM_BUFS > 1) ? $clog2(NUM_BUFS) : 1
) (
  // Clock and reset
  input wire logic          REF_CLK_I,
  input wire logic          RST_I,
  // Packet and handshake side
  input wire logic          SS_TOKEN_I,
  input wire logic          TOKEN_VALID_I,
  input wire logic          DATA_END_I,
  input wire logic          DATA_CRC_OK_I,
  input wire handshake_type HS_HANDSHAKE_O,
  input wire logic          HS_HANDSHAKE_VALID_O,
  // Downstream and complete-split side
  input wire logic          FS_REQ_VALID_O,
  input wire logic [IW-1:0] FS_REQ_INDEX_O,
  input wire logic          FS_TAKE_I,
  input wire logic          CS_LOOKUP_I,
  input wire logic          CS_ANSWER_VALID_O,
  input wire cs_answer_type CS_ANSWER_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  a_hs_one_pulse: assert property (
    HS_HANDSHAKE_VALID_O |=> !HS_HANDSHAKE_VALID_O) else $error("handshake too long");
  a_hs_has_cause: assert property (
    HS_HANDSHAKE_VALID_O |-> $past(TOKEN_VALID_I, 2) || $past(TOKEN_VALID_I, 3) ||
    ($past(DATA_END_I, 2) && $past(DATA_CRC_OK_I, 2))) else $error("handshake without packet");
  a_bad_crc_silent: assert property (
    DATA_END_I && !DATA_CRC_OK_I && !TOKEN_VALID_I |-> ##2 !HS_HANDSHAKE_VALID_O)
    else $error("handshake after bad crc");
  a_abort_silent: assert property (
    SS_TOKEN_I |=> !HS_HANDSHAKE_VALID_O) else $error("handshake after restart");
  a_late_token_silent: assert property (
    SS_TOKEN_I ##1 (!TOKEN_VALID_I && !SS_TOKEN_I) [*8] ##1 (TOKEN_VALID_I && !SS_TOKEN_I)
    |=> !HS_HANDSHAKE_VALID_O [*3]) else $error("late token answered");
  a_offer_holds: assert property (
    FS_REQ_VALID_O && !FS_TAKE_I |=> FS_REQ_VALID_O && $stable(FS_REQ_INDEX_O))
    else $error("offer dropped untaken");
  a_take_drops: assert property (
    FS_REQ_VALID_O && FS_TAKE_I |=> !FS_REQ_VALID_O) else $error("offer kept after take");
  a_cs_answer_next: assert property (
    CS_LOOKUP_I |=> CS_ANSWER_VALID_O) else $error("lookup not answered");
  a_cs_answer_cause: assert property (
    CS_ANSWER_VALID_O |-> $past(CS_LOOKUP_I)) else $error("answer without lookup");

  c_ack: cover property (HS_HANDSHAKE_VALID_O && HS_HANDSHAKE_O == HS_ACK);
  c_nak: cover property (HS_HANDSHAKE_VALID_O && HS_HANDSHAKE_O == HS_NAK);
  c_result: cover property (CS_ANSWER_VALID_O && CS_ANSWER_O == CS_RESULT);
endmodule

bind split_bulk_start split_bulk_start_props #(.NUM_BUFS(NUM_BUFS), .WAIT_CYC(WAIT_CYC))
  i_split_bulk_start_props (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .SS_TOKEN_I(SS_TOKEN_I),
  .TOKEN_VALID_I(TOKEN_VALID_I), .DATA_END_I(DATA_END_I), .DATA_CRC_OK_I(DATA_CRC_OK_I),
  .HS_HANDSHAKE_O(HS_HANDSHAKE_O), .HS_HANDSHAKE_VALID_O(HS_HANDSHAKE_VALID_O),
  .FS_REQ_VALID_O(FS_REQ_VALID_O), .FS_REQ_INDEX_O(FS_REQ_INDEX_O), .FS_TAKE_I(FS_TAKE_I),
  .CS_LOOKUP_I(CS_LOOKUP_I), .CS_ANSWER_VALID_O(CS_ANSWER_VALID_O),
  .CS_ANSWER_O(CS_ANSWER_O));

// File: sim/split_host_model.sv
`timescale 1ns/100ps
module split_host_model
  import split_pkg::*;
#(
  parameter int WAIT_CYC = 8
) (
  // Clock
  input  wire logic  clk_i,
  // Packets toward the translator
  output logic       ss_token_o,
  output logic [6:0] ss_addr_o,
  output logic [3:0] ss_ep_o,
  output logic       ss_ctrl_o,
  output logic       token_valid_o,
  output tok_type    token_kind_o,
  output logic       data_byte_valid_o,
  output logic [7:0] data_byte_o,
  output logic       data_end_o,
  output logic       data_crc_ok_o
);
  initial begin
    ss_token_o = 1'b0;
    ss_addr_o = 7'h00;
    ss_ep_o = 4'h0;
    ss_ctrl_o = 1'b0;
    token_valid_o = 1'b0;
    token_kind_o = TOK_OUT;
    data_byte_valid_o = 1'b0;
    data_byte_o = 8'h00;
    data_end_o = 1'b0;
    data_crc_ok_o = 1'b1;
  end

  // every frame sent here is a split
  // faults (bad CRC, late token) only on request, no retries
  task automatic send(input logic [3:0] e, input logic c, input tok_type k, input int nb,
                      input logic [7:0] s, input bit crc, input bit late);
    @(posedge clk_i);
    ss_token_o <= 1'b1;
    ss_addr_o <= 7'h11;
    ss_ep_o <= e;
    ss_ctrl_o <= c;
    @(posedge clk_i);
    ss_token_o <= 1'b0;
    ss_addr_o <= 7'h6e;
    ss_ep_o <= ~e;
    ss_ctrl_o <= ~c;
    token_valid_o <= !late;
    token_kind_o <= k;
    if (late) begin
      repeat (WAIT_CYC) @(posedge clk_i);
      token_valid_o <= 1'b1;
    end
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_i);
      token_valid_o <= 1'b0;
      data_byte_valid_o <= 1'b1;
      data_byte_o <= s + 8'(i);
      data_end_o <= (i == nb - 1);
      data_crc_ok_o <= crc;
    end
    @(posedge clk_i);
    token_valid_o <= 1'b0;
    data_byte_valid_o <= 1'b0;
    data_byte_o <= ~data_byte_o;
    data_end_o <= 1'b0;
  endtask
endmodule

// File: sim/split_bulk_start_tb_top.sv
`timescale 1ns/100ps
module split_bulk_start_tb_top;
  import split_pkg::*;
  // Clock, reset, counters
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  int            n_fail = 0;
  int            cmp_count = 0;
  // Host packets
  wire logic     ss_tok, ss_ctl, tok_v, db_v, d_end, crc_ok;
  wire logic [6:0] ss_addr;
  wire logic [3:0] ss_ep;
  wire logic [7:0] db;
  wire tok_type  tok_k;
  // Downstream, complete-split and read inputs
  logic          fs_take = 1'b0, fs_done = 1'b0, cs_look = 1'b0, cs_ctl = 1'b0;
  logic          cs_done = 1'b0, cs_didx = 1'b0, rd_en = 1'b0, rd_idx = 1'b0;
  logic [6:0]    cs_addr = 7'h00;
  logic [3:0]    cs_ep = 4'h0;
  logic [5:0]    rd_off = 6'h00;
  fs_result_type fs_res = FS_NAK;
  logic          fs_wr = 1'b0, cs_dir = 1'b0;
  logic [5:0]    fs_off = 6'h00;
  logic [7:0]    fs_wd = 8'h00;
  logic [6:0]    fs_len = 7'h02;
  // Outputs
  handshake_type hs_code;
  cs_answer_type ca;
  fs_result_type ca_res;
  logic          hs_v, fq_v, fq_idx, ca_v, ca_idx;
  logic [7:0]    rd_data;
  logic [6:0]    fq_addr, fq_len, ca_len;
  logic [3:0]    fq_ep;
  tok_type       fq_kind;

  always #2 clk = ~clk;

  split_host_model #(.WAIT_CYC(8)) i_split_host_model (.clk_i(clk), .ss_token_o(ss_tok),
    .ss_addr_o(ss_addr), .ss_ep_o(ss_ep), .ss_ctrl_o(ss_ctl), .token_valid_o(tok_v),
    .token_kind_o(tok_k), .data_byte_valid_o(db_v), .data_byte_o(db), .data_end_o(d_end),
    .data_crc_ok_o(crc_ok));

  split_bulk_start #(.NUM_BUFS(2), .BUF_BYTES(64), .WAIT_CYC(8)) i_split_bulk_start (
    .REF_CLK_I(clk), .RST_I(rst), .SS_TOKEN_I(ss_tok), .SS_ADDR_I(ss_addr), .SS_EP_I(ss_ep),
    .SS_CTRL_I(ss_ctl), .TOKEN_VALID_I(tok_v), .TOKEN_KIND_I(tok_k), .DATA_BYTE_VALID_I(db_v),
    .DATA_BYTE_I(db), .DATA_END_I(d_end), .DATA_CRC_OK_I(crc_ok), .HS_HANDSHAKE_O(hs_code),
    .HS_HANDSHAKE_VALID_O(hs_v), .FS_REQ_VALID_O(fq_v), .FS_REQ_INDEX_O(fq_idx),
    .FS_REQ_ADDR_O(fq_addr), .FS_REQ_EP_O(fq_ep), .FS_REQ_KIND_O(fq_kind),
    .FS_REQ_LENGTH_O(fq_len), .FS_TAKE_I(fs_take), .FS_WR_VALID_I(fs_wr),
    .FS_WR_OFFSET_I(fs_off), .FS_WR_DATA_I(fs_wd), .FS_DONE_I(fs_done),
    .FS_RESULT_I(fs_res), .FS_LENGTH_I(fs_len), .CS_LOOKUP_I(cs_look), .CS_ADDR_I(cs_addr),
    .CS_EP_I(cs_ep), .CS_CTRL_I(cs_ctl), .CS_DIR_IN_I(cs_dir), .CS_ANSWER_VALID_O(ca_v),
    .CS_ANSWER_O(ca), .CS_INDEX_O(ca_idx), .CS_RESULT_O(ca_res), .CS_LENGTH_O(ca_len),
    .CS_DONE_I(cs_done), .CS_DONE_INDEX_I(cs_didx), .RD_EN_I(rd_en), .RD_INDEX_I(rd_idx),
    .RD_OFFSET_I(rd_off), .RD_DATA_O(rd_data));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Frame, then the handshake code or 00 for silence
  task automatic ss(input logic [3:0] e, input logic c, input tok_type k, input int nb,
                    input logic [7:0] s, input bit crc, input bit late, input logic [7:0] exp);
    logic [7:0] seen;
    i_split_host_model.send(e, c, k, nb, s, crc, late);
    seen = 8'h00;
    for (int i = 0; i < 10 && seen == 8'h00; i++) begin
      @(negedge clk);
      if (hs_v === 1'b1) seen = 8'(hs_code);
    end
    chk("handshake", exp, seen);
    if (exp != 8'h00 && seen == 8'h00) give_verdict();
  endtask

  task automatic cs_q(input logic [3:0] e, input logic c, input logic [7:0] exp, input logic ix);
    @(posedge clk);
    cs_look <= 1'b1;
    cs_addr <= 7'h11;
    cs_ep <= e;
    cs_ctl <= c;
    cs_dir <= c;
    @(posedge clk);
    cs_look <= 1'b0;
    @(negedge clk);
    chk("cs valid", 8'h01, 8'(ca_v));
    chk("cs answer", exp, 8'(ca));
    if (exp != 8'(CS_STALL)) chk("cs index", 8'(ix), 8'(ca_idx));
    if (exp == 8'(CS_RESULT)) chk("cs result", 8'(FS_NAK), 8'(ca_res));
    if (exp == 8'(CS_RESULT)) chk("cs length", 8'(fs_len), 8'(ca_len));
  endtask

  task automatic offer(input logic ix, input logic [3:0] e, input tok_type k, input logic [6:0] n);
    for (int i = 0; i < 20 && fq_v !== 1'b1; i++) @(negedge clk);
    chk("offer", 8'h01, 8'(fq_v));
    if (fq_v !== 1'b1) give_verdict();
    chk("offer index", 8'(ix), 8'(fq_idx));
    chk("offer addr", 8'h11, 8'(fq_addr));
    chk("offer ep", 8'(e), 8'(fq_ep));
    chk("offer kind", 8'(k), 8'(fq_kind));
    chk("offer length", 8'(n), 8'(fq_len));
  endtask

  task automatic rd(input logic ix, input logic [5:0] o, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_idx <= ix;
    rd_off <= o;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk("payload", exp, rd_data);
  endtask

  task automatic t_errors;
    ss(4'h5, 1'b0, TOK_OUT, 2, 8'h40, 1'b0, 1'b0, 8'h00);
    ss(4'h5, 1'b0, TOK_IN, 0, 8'h00, 1'b1, 1'b1, 8'h00);
    chk("no offer", 8'h00, 8'(fq_v));
    $display("test errors done");
  endtask

  task automatic t_fresh_repeat;
    ss(4'h1, 1'b0, TOK_OUT, 2, 8'ha0, 1'b1, 1'b0, 8'(HS_ACK));
    offer(1'b1, 4'h1, TOK_OUT, 7'h02);
    ss(4'h1, 1'b0, TOK_OUT, 2, 8'h50, 1'b1, 1'b0, 8'(HS_ACK));
    rd(1'b1, 6'h00, 8'ha0);
    rd(1'b1, 6'h01, 8'ha1);
    $display("test fresh_repeat done");
  endtask

  task automatic t_full;
    ss(4'h2, 1'b1, TOK_SETUP, 1, 8'h60, 1'b1, 1'b0, 8'(HS_ACK));
    ss(4'h2, 1'b1, TOK_IN, 0, 8'h00, 1'b1, 1'b0, 8'(HS_ACK));
    ss(4'h1, 1'b0, TOK_IN, 0, 8'h00, 1'b1, 1'b0, 8'(HS_NAK));
    ss(4'h3, 1'b0, TOK_OUT, 1, 8'h70, 1'b1, 1'b0, 8'(HS_NAK));
    offer(1'b1, 4'h1, TOK_OUT, 7'h02);
    $display("test full done");
  endtask

  task automatic t_release;
    cs_q(4'h2, 1'b1, 8'(CS_NYET), 1'b0);
    @(posedge clk);
    fs_take <= 1'b1;
    @(posedge clk);
    fs_take <= 1'b0;
    fs_wr <= 1'b1;
    fs_off <= 6'h02;
    fs_wd <= 8'h5a;
    @(posedge clk);
    fs_wr <= 1'b0;
    fs_done <= 1'b1;
    @(posedge clk);
    fs_done <= 1'b0;
    cs_q(4'h1, 1'b0, 8'(CS_RESULT), 1'b1);
    @(posedge clk);
    cs_done <= 1'b1;
    cs_didx <= 1'b1;
    @(posedge clk);
    cs_done <= 1'b0;
    cs_q(4'h1, 1'b0, 8'(CS_STALL), 1'b0);
    ss(4'h1, 1'b0, TOK_OUT, 1, 8'h30, 1'b1, 1'b0, 8'(HS_ACK));
    offer(1'b0, 4'h2, TOK_SETUP, 7'h01);
    rd(1'b1, 6'h00, 8'h30);
    rd(1'b1, 6'h02, 8'h5a);
    $display("test release done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_errors();
    t_fresh_repeat();
    t_full();
    t_release();
    give_verdict();
  end
endmodule
